// [iq_pkg.sv]
// Package for the interrupt queue writer: register map, descriptor
// field layout, event and error codes, reset values.
// Assumes a single 125 MHz clock domain.
package iq_pkg;

  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_QUEUE_BASE     = 8'h00;
  localparam logic [7:0] OFF_QUEUE_LENGTH   = 8'h04;
  localparam logic [7:0] OFF_QUEUE_CONTROL  = 8'h08;
  localparam logic [7:0] OFF_QUEUE_STATUS   = 8'h0c;
  localparam logic [7:0] OFF_QUEUE_FILL_PTR = 8'h10;

  // Reset values
  localparam logic [31:0] RST_QUEUE_BASE   = 32'h0000_0000;
  localparam logic [14:0] RST_QUEUE_LENGTH = 15'h0001;

  // Length field
  localparam int LEN_MSB = 14;
  localparam int LEN_W   = 15;

  // Descriptor field positions
  localparam int DIR_BIT     = 31;
  localparam int GRP_LO_MSB  = 30;
  localparam int GRP_LO_LSB  = 29;
  localparam int CH_MSB      = 28;
  localparam int CH_LSB      = 24;
  localparam int EVT_MSB     = 23;
  localparam int EVT_LSB     = 20;
  localparam int ERR_MSB     = 19;
  localparam int ERR_LSB     = 16;
  localparam int LOST_BIT    = 15;
  localparam int GRP_HI_BIT  = 14;
  localparam int CNT_MSB     = 13;

  // Event codes
  localparam logic [3:0] EV_NONE                 = 4'h0;
  localparam logic [3:0] EV_REQUEST_ACK          = 4'h1;
  localparam logic [3:0] EV_BUFFER_DONE          = 4'h2;
  localparam logic [3:0] EV_MESSAGE_DONE         = 4'h3;
  localparam logic [3:0] EV_PAD_END              = 4'h4;
  localparam logic [3:0] EV_TO_ABORT_CODE        = 4'h5;
  localparam logic [3:0] EV_TO_IDLE_CODE         = 4'h6;
  localparam logic [3:0] EV_FRAME_RECOVERY       = 4'h7;
  localparam logic [3:0] EV_ERROR_MONITOR_UP     = 4'h8;
  localparam logic [3:0] EV_ERROR_MONITOR_DOWN   = 4'h9;
  localparam logic [3:0] EV_FILTERED_MESSAGE     = 4'ha;

  // Error codes
  localparam logic [3:0] ER_NONE                 = 4'h0;
  localparam logic [3:0] ER_INTERNAL_BUFFER      = 4'h1;
  localparam logic [3:0] ER_FRAME_ALIGN_CHANGE   = 4'h2;
  localparam logic [3:0] ER_OWNER_BIT            = 4'h3;
  localparam logic [3:0] ER_PROTECTION_VIOLATION = 4'h4;
  localparam logic [3:0] ER_OUT_OF_FRAME         = 4'h8;
  localparam logic [3:0] ER_FCS                  = 4'h9;
  localparam logic [3:0] ER_ALIGNMENT            = 4'ha;
  localparam logic [3:0] ER_ABORT_TERMINATION    = 4'hb;
  localparam logic [3:0] ER_LONG_MESSAGE         = 4'hc;
  localparam logic [3:0] ER_SHORT_MESSAGE        = 4'hd;
  localparam logic [3:0] ER_ERROR_RATE_ALARM     = 4'he;
  localparam logic [3:0] ER_PARITY_ERROR         = 4'hf;

  // Control register bits
  localparam int CTL_MASTER_EN = 0;
  localparam int CTL_FETCH     = 1;

  // Pending FIFO depth
  localparam int FIFO_DEPTH = 8;

endpackage

// [iq_fifo.sv]
// Small ordered FIFO holding descriptors awaiting transfer.
// The tail entry may have bits ORed in place (lost / parity flags).
`timescale 1ns/10ps
module iq_fifo
  import iq_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_n,
  // Push side
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] push_data,
  input  wire logic [WIDTH-1:0] tail_or,
  output logic                  full,
  // Pop side
  input  wire logic             pop,
  output logic [WIDTH-1:0]      head_data,
  output logic                  empty
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } fifo_state_t;

  fifo_state_t      st_ff;
  fifo_state_t      nxt_st;
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    tail_idx;
  logic             do_push;
  logic             do_pop;

  assign empty     = (st_ff.wr == st_ff.rd);
  assign full      = (st_ff.wr[AW-1:0] == st_ff.rd[AW-1:0]) &&
                     (st_ff.wr[AW] != st_ff.rd[AW]);
  assign head_data = mem_ff[st_ff.rd[AW-1:0]];
  assign tail_idx  = st_ff.wr[AW-1:0] - 1'b1;
  assign do_push   = push && !full;
  assign do_pop    = pop && !empty;

  always_comb begin
    nxt_st = st_ff;
    if (do_push) begin
      nxt_st.wr = st_ff.wr + 1'b1;
    end
    if (do_pop) begin
      nxt_st.rd = st_ff.rd + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Storage has no reset; tail flag merge skips the head being popped
  always_ff @(posedge mclk) begin
    if (do_push) begin
      mem_ff[st_ff.wr[AW-1:0]] <= push_data;
    end
    if (!empty && (tail_or != '0) &&
        !(do_pop && st_ff.wr == st_ff.rd + 1'b1)) begin
      mem_ff[tail_idx] <= mem_ff[tail_idx] | tail_or;
    end
  end
endmodule

// [iq_writer.sv]
// Interrupt queue writer: builds 32-bit interrupt descriptors and
// writes them as bus master into a circular queue in shared memory.
// Assumes a simple master port (req/done) toward the PCI core.
//
// Local design decision: the strobed register port.
`timescale 1ns/10ps
module iq_writer
  import iq_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // Interrupt source
  input  wire logic        src_valid,
  input  wire logic        src_dir,
  input  wire logic [2:0]  src_group,
  input  wire logic [4:0]  src_channel,
  input  wire logic [3:0]  src_event,
  input  wire logic [3:0]  src_error,
  input  wire logic [13:0] src_count,
  input  wire logic        src_frame_clear,
  input  wire logic        parity_error,
  // Bus master port
  output logic             mst_req,
  output logic             mst_write,
  output logic [31:0]      mst_addr,
  output logic [31:0]      mst_wdata,
  input  wire logic        mst_done,
  input  wire logic [31:0] mst_rdata,
  // Status
  output logic             queue_busy
);
  typedef enum {ST_IDLE, ST_WRITE, ST_FETCH_BASE, ST_FETCH_LEN} wr_st_t;

  typedef struct packed {
    wr_st_t      state;
    logic [29:0] base;
    logic [14:0] len;
    logic [14:0] idx;
    logic        master_en;
    logic [31:0] fetch_ptr;
    logic [7:0]  frame_mask;
    logic        lost_seen;
    logic        mreq;
    logic        mwrite;
    logic [31:0] maddr;
    logic [31:0] mwdata;
    logic [31:0] rdata;
  } wr_state_t;

  wr_state_t   s_ff;
  wr_state_t   nxt_s;
  logic        fifo_full;
  logic        fifo_empty;
  logic        fifo_pop;
  logic        push;
  logic [31:0] push_word;
  logic [31:0] tail_or;
  logic [31:0] head;
  logic        legal;
  logic        frame_cond;
  logic        paired_ok;

  // Descriptor assembly
  always_comb begin
    push_word = '0;
    push_word[DIR_BIT] = src_dir;
    push_word[GRP_LO_MSB:GRP_LO_LSB] = src_group[1:0];
    push_word[CH_MSB:CH_LSB] = src_channel;
    push_word[GRP_HI_BIT] = src_group[2];
    push_word[EVT_MSB:EVT_LSB] = src_event;
    push_word[ERR_MSB:ERR_LSB] = src_error;
    if (src_event == EV_BUFFER_DONE ||
        (src_event == EV_MESSAGE_DONE && !src_dir)) begin
      push_word[CNT_MSB:0] = src_count;
    end
  end

  // Only buffer/message done may carry an error; parity goes by flag
  assign paired_ok = (src_event == EV_NONE) || (src_error == ER_NONE) ||
                     ((src_event == EV_BUFFER_DONE ||
                       src_event == EV_MESSAGE_DONE) &&
                      src_error != ER_PROTECTION_VIOLATION &&
                      src_error != ER_ERROR_RATE_ALARM &&
                      src_error != ER_PARITY_ERROR);
  assign frame_cond = (src_error == ER_OUT_OF_FRAME ||
                       src_error == ER_FRAME_ALIGN_CHANGE);
  assign legal = src_valid && paired_ok &&
                 (src_event != EV_NONE || src_error != ER_NONE) &&
                 !(frame_cond && s_ff.frame_mask[src_group]);
  assign push  = legal && !fifo_full;

  // Flags merged into the newest queued descriptor
  always_comb begin
    tail_or = '0;
    if (legal && fifo_full) begin
      tail_or[LOST_BIT] = 1'b1;
    end
    if (parity_error) begin
      tail_or[ERR_MSB:ERR_LSB] = ER_PARITY_ERROR;
    end
  end

  assign fifo_pop = (s_ff.state == ST_WRITE) && mst_done;

  iq_fifo #(
    .WIDTH (32),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .push      (push),
    .push_data (push_word),
    .tail_or   (tail_or),
    .full      (fifo_full),
    .pop       (fifo_pop),
    .head_data (head),
    .empty     (fifo_empty)
  );

  always_comb begin
    nxt_s = s_ff;
    nxt_s.rdata = '0;
    // Frame condition latch per group; a new condition beats a clear
    if (src_frame_clear) begin
      nxt_s.frame_mask[src_group] = 1'b0;
    end
    if (legal && frame_cond) begin
      nxt_s.frame_mask[src_group] = 1'b1;
    end
    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        OFF_QUEUE_BASE: begin
          nxt_s.base = reg_wdata[31:2];
          nxt_s.idx  = '0;
        end
        OFF_QUEUE_LENGTH: begin
          nxt_s.len = reg_wdata[LEN_MSB:0];
          nxt_s.idx = '0;
        end
        OFF_QUEUE_CONTROL: begin
          nxt_s.master_en = reg_wdata[CTL_MASTER_EN];
        end
        OFF_QUEUE_FILL_PTR: begin
          nxt_s.fetch_ptr = {reg_wdata[31:2], 2'b00};
        end
        OFF_QUEUE_STATUS: begin
          if (reg_wdata[1]) begin
            nxt_s.lost_seen = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // Overflow beats a software clear in the same cycle
    if (legal && fifo_full) begin
      nxt_s.lost_seen = 1'b1;
    end
    // Register reads, data the cycle after
    if (reg_rd) begin
      case (reg_addr)
        OFF_QUEUE_BASE:     nxt_s.rdata = {s_ff.base, 2'b00};
        OFF_QUEUE_LENGTH:   nxt_s.rdata = {17'h00000, s_ff.len};
        OFF_QUEUE_CONTROL:  nxt_s.rdata = {31'h0, s_ff.master_en};
        OFF_QUEUE_STATUS:   nxt_s.rdata = {15'h0, s_ff.idx,
                                           s_ff.lost_seen, !fifo_empty};
        OFF_QUEUE_FILL_PTR: nxt_s.rdata = s_ff.fetch_ptr;
        default:            nxt_s.rdata = '0;
      endcase
    end
    case (s_ff.state)
      ST_IDLE: begin
        if (reg_wr && reg_addr == OFF_QUEUE_CONTROL &&
            reg_wdata[CTL_FETCH]) begin
          nxt_s.state  = ST_FETCH_BASE;
          nxt_s.mreq   = 1'b1;
          nxt_s.mwrite = 1'b0;
          nxt_s.maddr  = s_ff.fetch_ptr;
        end else if (!fifo_empty && s_ff.master_en) begin
          nxt_s.state  = ST_WRITE;
          nxt_s.mreq   = 1'b1;
          nxt_s.mwrite = 1'b1;
          nxt_s.maddr  = {s_ff.base + {15'h0, s_ff.idx}, 2'b00};
          nxt_s.mwdata = head;
        end
      end
      ST_WRITE: begin
        // Refresh data so late-merged flags go out
        nxt_s.mwdata = head;
        if (mst_done) begin
          nxt_s.state = ST_IDLE;
          nxt_s.mreq  = 1'b0;
          nxt_s.idx   = (s_ff.idx == s_ff.len) ? 15'h0000
                        : s_ff.idx + 15'h0001;
        end
      end
      ST_FETCH_BASE: begin
        if (mst_done) begin
          nxt_s.base  = mst_rdata[31:2];
          nxt_s.state = ST_FETCH_LEN;
          nxt_s.maddr = s_ff.fetch_ptr + 32'h0000_0004;
        end
      end
      ST_FETCH_LEN: begin
        if (mst_done) begin
          nxt_s.len   = mst_rdata[LEN_MSB:0];
          nxt_s.idx   = '0;
          nxt_s.state = ST_IDLE;
          nxt_s.mreq  = 1'b0;
        end
      end
      default: nxt_s.state = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff       <= '0;
      s_ff.state <= ST_IDLE;
      s_ff.base  <= RST_QUEUE_BASE[31:2];
      s_ff.len   <= RST_QUEUE_LENGTH;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign reg_rdata  = s_ff.rdata;
  assign mst_req    = s_ff.mreq;
  assign mst_write  = s_ff.mwrite;
  assign mst_addr   = s_ff.maddr;
  assign mst_wdata  = s_ff.mwdata;
  assign queue_busy = !fifo_empty;

  // Writes happen only with mastering on, at base-relative address
  master_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(mst_req) && mst_write |-> $past(s_ff.master_en))
    else $error("queue write without master enable");

  addr_align_a: assert property (@(posedge mclk) disable iff (!rst_n)
    mst_req && mst_write |-> mst_addr[1:0] == 2'b00)
    else $error("queue address not word aligned");

  index_wrap_a: assert property (@(posedge mclk) disable iff (!rst_n)
    s_ff.state == ST_WRITE && mst_done && s_ff.idx == s_ff.len
    |=> s_ff.idx == 15'h0000)
    else $error("index did not wrap");

  sequence fetch_done_s;
    s_ff.state == ST_FETCH_LEN && mst_done;
  endsequence
  fetch_load_a: assert property (@(posedge mclk) disable iff (!rst_n)
    fetch_done_s |=> s_ff.len == $past(mst_rdata[LEN_MSB:0]))
    else $error("fetched length not loaded");

  count_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
    push && src_event != EV_BUFFER_DONE && src_event != EV_MESSAGE_DONE
    |-> push_word[CNT_MSB:0] == 14'h0000)
    else $error("byte count in non-done descriptor");

  lost_alone_a: assert property (@(posedge mclk) disable iff (!rst_n)
    push |-> push_word[EVT_MSB:ERR_LSB] != 8'h00 &&
             !push_word[LOST_BIT])
    else $error("empty or pre-flagged descriptor pushed");

  frame_once_a: assert property (@(posedge mclk) disable iff (!rst_n)
    push && frame_cond ##1 !src_frame_clear[*1]
    |-> !(push && frame_cond && src_group == $past(src_group)))
    else $error("second frame interrupt for same group");

  field_map_a: assert property (@(posedge mclk) disable iff (!rst_n)
    push |-> push_word[GRP_HI_BIT] == src_group[2] &&
             push_word[CH_MSB:CH_LSB] == src_channel)
    else $error("group or channel field misplaced");
endmodule

// [iq_host_mem.sv]
// Host-side memory model facing the writer's bus master port.
// Assumes one clock; the bench sets the answer delay through latency.
`timescale 1ns/10ps
module iq_host_mem (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Master port
  input  wire logic        mst_req,
  input  wire logic        mst_write,
  input  wire logic [31:0] mst_addr,
  input  wire logic [31:0] mst_wdata,
  output logic             mst_done,
  output logic [31:0]      mst_rdata,
  // Answer delay in cycles
  input  wire logic [3:0]  latency
);
  logic [31:0] mem [logic [29:0]];
  logic [63:0] wq [$];
  logic [3:0]  wait_cnt;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mst_done  <= 1'b0;
      mst_rdata <= 32'h5a5a_a5a5;
      wait_cnt  <= 4'h0;
    end else begin
      mst_done  <= 1'b0;
      // Read data is meaningless outside the done cycle
      mst_rdata <= ~mst_rdata;
      if (mst_req && !mst_done) begin
        if (wait_cnt >= latency) begin
          wait_cnt <= 4'h0;
          mst_done <= 1'b1;
          if (mst_write) begin
            mem[mst_addr[31:2]] = mst_wdata;
            // Host side only reads queue entries, never rewrites them
            wq.push_back({mst_addr, mst_wdata});
          end else if (mem.exists(mst_addr[31:2])) begin
            mst_rdata <= mem[mst_addr[31:2]];
          end else begin
            mst_rdata <= 32'h0;
          end
        end else begin
          wait_cnt <= wait_cnt + 4'h1;
        end
      end
    end
  end
endmodule

// [tb_interrupt_queue_writer.sv]
// Self-checking bench for the interrupt queue writer.
// Assumes the host memory model on the master port.
`timescale 1ns/10ps
module tb_interrupt_queue_writer
  import iq_pkg::*;
;
  logic        mclk, rst_n;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, mst_addr, mst_wdata, mst_rdata;
  logic        reg_wr, reg_rd, mst_req, mst_write, mst_done, queue_busy;
  logic        src_valid, src_dir, src_frame_clear, parity_error;
  logic [2:0]  src_group;
  logic [4:0]  src_channel;
  logic [3:0]  src_event, src_error, latency;
  logic [13:0] src_count;
  logic [31:0] qbase, qlen, widx, rd;
  logic [31:0] expq [$];
  int          miscompares, cmp_count, n;

  iq_writer iq_writer_inst (
    .mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .src_valid, .src_dir, .src_group, .src_channel, .src_event,
    .src_error, .src_count, .src_frame_clear, .parity_error, .mst_req,
    .mst_write, .mst_addr, .mst_wdata, .mst_done, .mst_rdata, .queue_busy
  );
  iq_host_mem iq_host_mem_inst (
    .mclk, .rst_n, .mst_req, .mst_write, .mst_addr, .mst_wdata,
    .mst_done, .mst_rdata, .latency
  );

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  function automatic logic [31:0] desc(logic d, logic [2:0] g, logic [4:0] c,
      logic [3:0] ev, logic [3:0] er, logic [13:0] cnt);
    logic [13:0] k;
    k = (ev == EV_BUFFER_DONE || (ev == EV_MESSAGE_DONE && !d)) ? cnt : '0;
    return {d, g[1:0], c, ev, er, 1'b0, g[2], k};
  endfunction

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus_write(logic [7:0] a, logic [31:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask

  task automatic bus_read(logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic set_queue(logic [31:0] b, logic [31:0] l);
    bus_write(OFF_QUEUE_BASE, b);
    bus_write(OFF_QUEUE_LENGTH, l);
    qbase = {b[31:2], 2'b00};
    qlen  = {17'h0, l[14:0]};
    widx  = '0;
  endtask

  // Valid stays high so consecutive calls give back-to-back requests
  task automatic post(logic d, logic [2:0] g, logic [4:0] c, logic [3:0] ev,
      logic [3:0] er, logic [13:0] cnt, bit ok);
    @(posedge mclk);
    {src_dir, src_group, src_channel, src_event, src_error} <= {d, g, c, ev, er};
    src_count <= cnt;
    src_valid <= 1'b1;
    if (ok) expq.push_back(desc(d, g, c, ev, er, cnt));
  endtask

  task automatic src_idle();
    @(posedge mclk);
    src_valid <= 1'b0;
  endtask

  task automatic expect_write(logic [31:0] exp);
    logic [63:0] w;
    int k;
    k = 0;
    while (iq_host_mem_inst.wq.size() == 0 && k < 400) begin
      @(posedge mclk);
      k++;
    end
    if (k >= 400) begin
      miscompares++;
      $display("MISMATCH queue write expected %h seen none", exp);
      tally_and_finish();
    end else begin
      w = iq_host_mem_inst.wq.pop_front();
      check("write address", w[63:32], qbase + (widx << 2));
      check("descriptor", w[31:0], exp);
      widx = (widx == qlen) ? '0 : widx + 1;
    end
  endtask

  task automatic drain();
    src_idle();
    while (expq.size() > 0) expect_write(expq.pop_front());
  endtask

  initial begin
    rst_n = 1'b0;
    {reg_addr, reg_wdata, reg_wr, reg_rd, latency} = '0;
    {src_valid, src_dir, src_group, src_channel, src_event} = '0;
    {src_error, src_count, src_frame_clear, parity_error} = '0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    bus_read(OFF_QUEUE_BASE, rd);
    check("base reset", rd, RST_QUEUE_BASE);
    bus_read(OFF_QUEUE_LENGTH, rd);
    check("length reset", rd, {17'h0, RST_QUEUE_LENGTH});
    @(posedge mclk);
    #1 check("read data clears", reg_rdata, 32'h0);
    bus_read(8'h20, rd);
    check("unmapped read", rd, 32'h0);
    set_queue(32'h0000_1003, 32'hffff_8003);
    bus_read(OFF_QUEUE_BASE, rd);
    check("base aligned", rd, 32'h0000_1000);
    bus_read(OFF_QUEUE_LENGTH, rd);
    check("length field", rd, 32'h3);
    $display("test registers finished");

    bus_write(OFF_QUEUE_CONTROL, 32'h1);
    latency <= 4'h3;
    post(1'b0, 3'h5, 5'h11, EV_BUFFER_DONE, ER_NONE, 14'h1abc, 1);
    post(1'b1, 3'h2, 5'h1f, EV_MESSAGE_DONE, ER_NONE, 14'h0123, 1);
    post(1'b0, 3'h7, 5'h00, EV_MESSAGE_DONE, ER_FCS, 14'h3fff, 1);
    post(1'b1, 3'h4, 5'h0a, EV_REQUEST_ACK, ER_NONE, 14'h0077, 1);
    post(1'b0, 3'h1, 5'h03, EV_NONE, ER_PROTECTION_VIOLATION, 14'h0, 1);
    drain();
    $display("test format and wrap finished");

    latency <= 4'h0;
    for (int i = 1; i <= 10; i++) begin
      post(i[0], 3'h0, 5'h02, 4'(i), ER_NONE, 14'h0011, 1);
      post(1'b0, 3'h0, 5'h02, 4'(i), ER_FCS, 14'h0, i == 2 || i == 3);
      drain();
    end
    for (int i = 1; i <= 15; i++) begin
      if (i >= 5 && i <= 7) continue;
      post(1'b0, 3'(i), 5'h04, EV_NONE, 4'(i), 14'h0, 1);
      post(1'b0, 3'(i + 3), 5'h05, 4'(2 + i % 2), 4'(i), 14'h0042,
           !(4'(i) inside {ER_PROTECTION_VIOLATION, ER_ERROR_RATE_ALARM,
                           ER_PARITY_ERROR}));
      drain();
    end
    post(1'b0, 3'h0, 5'h06, EV_NONE, ER_NONE, 14'h0, 0);
    drain();
    $display("test combinations finished");

    post(1'b0, 3'h6, 5'h03, EV_NONE, ER_OUT_OF_FRAME, 14'h0, 1);
    post(1'b0, 3'h6, 5'h04, EV_NONE, ER_OUT_OF_FRAME, 14'h0, 0);
    drain();
    @(posedge mclk);
    src_group       <= 3'h6;
    src_frame_clear <= 1'b1;
    @(posedge mclk);
    src_frame_clear <= 1'b0;
    post(1'b0, 3'h6, 5'h07, EV_NONE, ER_OUT_OF_FRAME, 14'h0, 1);
    drain();
    $display("test frame lock finished");

    bus_write(OFF_QUEUE_CONTROL, 32'h0);
    for (int i = 0; i <= FIFO_DEPTH; i++)
      post(i[0], 3'h1, 5'(i), EV_BUFFER_DONE, ER_NONE, 14'(i + 1),
           i < FIFO_DEPTH);
    expq[FIFO_DEPTH - 1][LOST_BIT] = 1'b1;
    src_idle();
    bus_read(OFF_QUEUE_STATUS, rd);
    check("status flags", {30'h0, rd[1:0]}, 32'h3);
    check("queue busy", {31'h0, queue_busy}, 32'h1);
    latency <= 4'h6;
    bus_write(OFF_QUEUE_CONTROL, 32'h1);
    drain();
    repeat (3) @(posedge mclk);
    bus_read(OFF_QUEUE_STATUS, rd);
    check("status after drain", rd, {15'h0, widx[14:0], 2'b10});
    bus_write(OFF_QUEUE_STATUS, 32'h2);
    bus_read(OFF_QUEUE_STATUS, rd);
    check("lost cleared", {30'h0, rd[1:0]}, 32'h0);
    $display("test overflow finished");

    bus_write(OFF_QUEUE_CONTROL, 32'h0);
    post(1'b0, 3'h3, 5'h09, EV_BUFFER_DONE, ER_NONE, 14'h0055, 1);
    src_idle();
    parity_error <= 1'b1;
    @(posedge mclk);
    parity_error <= 1'b0;
    expq[$][ERR_MSB:ERR_LSB] = ER_PARITY_ERROR;
    bus_write(OFF_QUEUE_CONTROL, 32'h1);
    drain();
    $display("test parity finished");

    set_queue(32'h0000_1000, 32'h1);
    iq_host_mem_inst.mem[30'h800] = 32'h0000_4000;
    iq_host_mem_inst.mem[30'h801] = 32'h0000_0001;
    bus_write(OFF_QUEUE_FILL_PTR, 32'h0000_2000);
    bus_read(OFF_QUEUE_FILL_PTR, rd);
    check("fetch pointer", rd, 32'h0000_2000);
    bus_write(OFF_QUEUE_CONTROL, 32'h3);
    n = 0;
    rd = '0;
    while (rd !== 32'h0000_4000 && n < 50) begin
      bus_read(OFF_QUEUE_BASE, rd);
      n++;
    end
    check("fetched base", rd, 32'h0000_4000);
    bus_read(OFF_QUEUE_LENGTH, rd);
    check("fetched length", rd, 32'h1);
    qbase = 32'h0000_4000;
    qlen  = 32'h1;
    for (int i = 0; i < 3; i++)
      post(1'b0, 3'h2, 5'(i), EV_MESSAGE_DONE, ER_ABORT_TERMINATION, 14'h9, 1);
    drain();
    $display("test fetch finished");

    repeat (20) @(posedge mclk);
    check("extra writes", 32'(iq_host_mem_inst.wq.size()), 32'h0);
    tally_and_finish();
  end
endmodule
